/* rtl/serial_io_pkg.sv */
// constants, field layout and state types of the serial channel
// Overview of operation
// - synchronous reception runs only with both transmit and receive enabled
// - handshake function selected: enabling receive drives the ready output low
// - handshake function selected: ready output goes high once reception begins
// - each rising shift clock edge loads the receive pin into the top bit, shifting right
// - after 8 shift clocks the byte goes to the buffer, flag set, ready low
// - receive-complete sets the receive interrupt request bit
// - reading the receive buffer clears the receive-complete flag
// - transmitter must run for synchronous reception; dummy data is shifted out meanwhile
// - internal clock starts with transmit enabled and data; external also needs pin edges
// - byte completing while flag set raises overrun (bit 4) and overwrites buffer
// - overrun never sets the receive interrupt request bit
// - asynchronous character length 7, 8 or 9 bits from mode bits 0 to 2
// - every asynchronous frame starts with one low start bit
// - optional parity bit after data makes ones count even or odd
// - frame ends with one or two high stop bits after parity or data
// - internal divider source is input clock over 2, 16, 64 or 512
// - divider divides by programmed value plus one, then by 16 for asynchronous bit rate, by 2 for synchronous
// - mode bit 3 picks divider source: 0 internal, 1 external clock pin
// - asynchronous mode detects overrun, parity, framing errors and an error sum
// - mode bits 2 to 0 equal to 001 select clock-synchronous mode
// - asynchronous transmit: start, data lsb first, parity, stops; idle line high
// - synchronous transmit shifts lsb first, changing on falling shift clock edges
package serial_io_pkg;
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CTRL0 = 8'h04;
	localparam logic [7:0] ADDR_BAUD = 8'h08;
	localparam logic [7:0] ADDR_TXBUF = 8'h0c;
	localparam logic [7:0] ADDR_CTRL1 = 8'h10;
	localparam logic [7:0] ADDR_RXBUF = 8'h14;
	localparam logic [7:0] ADDR_REQ = 8'h18;
	// ----------------------------------------------------------------
	// field positions and encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_SYNC = 3'h1;
	localparam logic [2:0] MODE_UART7 = 3'h4;
	localparam logic [2:0] MODE_UART8 = 3'h5;
	localparam logic [2:0] MODE_UART9 = 3'h6;
	localparam int MODE_EXT_BIT = 3;
	localparam int MODE_STOP2_BIT = 4;
	localparam int MODE_EVEN_BIT = 5;
	localparam int MODE_PAR_BIT = 6;
	localparam int MODE_SLEEP_BIT = 7;
	localparam int C0_RTS_BIT = 2;
	localparam int C1_TX_EN = 0;
	localparam int C1_TX_EMPTY = 1;
	localparam int C1_RX_EN = 2;
	localparam int C1_RX_DONE = 3;
	localparam int C1_OVERRUN = 4;
	localparam int C1_FRAMING = 5;
	localparam int C1_PARITY = 6;
	localparam int C1_ERR_SUM = 7;
	localparam int C1_TX_REG_EMPTY = 8;
	localparam int REQ_RX = 0;
	localparam int REQ_TX = 1;
	localparam logic [7:0] RESET_8 = 8'h00;
	// prescaler masks: tick when the low bits of a free counter are all ones
	localparam logic [8:0] DIV_MASK_2 = 9'h001;
	localparam logic [8:0] DIV_MASK_16 = 9'h00f;
	localparam logic [8:0] DIV_MASK_64 = 9'h03f;
	localparam logic [8:0] DIV_MASK_512 = 9'h1ff;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [3:0] SYNC_LAST = 4'h7;
	localparam logic [3:0] LEN_7 = 4'h7;
	localparam logic [3:0] LEN_8 = 4'h8;
	localparam logic [3:0] LEN_9 = 4'h9;
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;
	// character length from the mode field; synchronous mode is always 8
	function automatic logic [3:0] char_len(input logic [2:0] sel);
		unique case (sel)
			MODE_UART7: char_len = LEN_7;
			MODE_UART9: char_len = LEN_9;
			default: char_len = LEN_8;
		endcase
	endfunction : char_len
endpackage : serial_io_pkg

/* rtl/serial_io_uart.sv */
// serial channel: synchronous and asynchronous transfer behind an apb slave
`timescale 1ns/1ps
`default_nettype none
module serial_io_uart import serial_io_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic shift_clock_pin_in,
	output logic shift_clock_pin_out,
	output logic shift_clock_pin_oe,
	input wire logic permit_to_send_in,
	output logic ready_to_accept_out
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_reg, rst_n_sync_reg;
	// assertion is immediate, release waits two edges to avoid a ragged exit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_sync_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// apb slave and configuration
	// ----------------------------------------------------------------
	logic [7:0] mode_reg, ctrl0_reg, baud_reg;
	logic tx_en_reg, rx_en_reg, pready_reg, pslverr_reg;
	logic [31:0] prdata_reg, rd_word;
	logic mapped, apb_done, wr_done, rd_rxbuf, tx_empty_reg, tx_reg_empty_reg;
	logic [8:0] txbuf_reg, rx_buf_reg;
	logic rx_complete_reg, overrun_reg, ferr_reg, perr_reg, err_sum, rx_req_reg, tx_req_reg;
	logic is_sync, is_uart, ext_clk, rts_fn;

	assign is_sync = mode_reg[2:0] == MODE_SYNC;
	assign is_uart = mode_reg[2:0] == MODE_UART7 || mode_reg[2:0] == MODE_UART8
		|| mode_reg[2:0] == MODE_UART9;
	assign ext_clk = mode_reg[MODE_EXT_BIT];
	assign rts_fn = ctrl0_reg[C0_RTS_BIT];
	assign err_sum = overrun_reg | perr_reg | ferr_reg;
	assign mapped = paddr == ADDR_MODE || paddr == ADDR_CTRL0 || paddr == ADDR_BAUD
		|| paddr == ADDR_TXBUF || paddr == ADDR_CTRL1 || paddr == ADDR_RXBUF
		|| paddr == ADDR_REQ;
	assign apb_done = psel && penable && pready_reg;
	assign wr_done = apb_done && pwrite && mapped;
	assign rd_rxbuf = apb_done && !pwrite && paddr == ADDR_RXBUF;

	// read multiplexer, captured on the same edge that pready rises
	always_comb begin
		rd_word = '0;
		unique case (paddr)
			ADDR_MODE: rd_word[7:0] = mode_reg;
			ADDR_CTRL0: rd_word[7:0] = ctrl0_reg;
			ADDR_BAUD: rd_word[7:0] = baud_reg;
			ADDR_TXBUF: rd_word[8:0] = txbuf_reg;
			ADDR_CTRL1: begin
				rd_word[C1_TX_EN] = tx_en_reg;
				rd_word[C1_TX_EMPTY] = tx_empty_reg;
				rd_word[C1_RX_EN] = rx_en_reg;
				rd_word[C1_RX_DONE] = rx_complete_reg;
				rd_word[C1_OVERRUN] = overrun_reg;
				rd_word[C1_FRAMING] = ferr_reg;
				rd_word[C1_PARITY] = perr_reg;
				rd_word[C1_ERR_SUM] = err_sum;
				rd_word[C1_TX_REG_EMPTY] = tx_reg_empty_reg;
			end
			ADDR_RXBUF: rd_word[8:0] = rx_buf_reg;
			ADDR_REQ: begin
				rd_word[REQ_RX] = rx_req_reg;
				rd_word[REQ_TX] = tx_req_reg;
			end
			default: rd_word = '0;
		endcase
	end

	// every access takes one wait state so read data can come from a flop
	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && !mapped;
			if (psel && penable && !pready_reg)
				prdata_reg <= pwrite ? '0 : rd_word;
		end
	end

	// software-owned configuration
	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			mode_reg <= RESET_8;
			ctrl0_reg <= RESET_8;
			baud_reg <= RESET_8;
			tx_en_reg <= 1'b0;
			rx_en_reg <= 1'b0;
		end else if (wr_done) begin
			if (paddr == ADDR_MODE)
				mode_reg <= pwdata[7:0];
			if (paddr == ADDR_CTRL0)
				ctrl0_reg <= pwdata[7:0];
			if (paddr == ADDR_BAUD)
				baud_reg <= pwdata[7:0];
			if (paddr == ADDR_CTRL1) begin
				tx_en_reg <= pwdata[C1_TX_EN];
				rx_en_reg <= pwdata[C1_RX_EN];
			end
		end
	end

	// ----------------------------------------------------------------
	// baud-rate divider
	// ----------------------------------------------------------------
	logic [8:0] presc_reg, div_mask;
	logic [7:0] brg_cnt_reg;
	logic pin_prev_reg, pin_rise, pin_fall, src_tick, brg_tick;

	always_comb begin
		unique case (ctrl0_reg[1:0])
			2'h0: div_mask = DIV_MASK_2;
			2'h1: div_mask = DIV_MASK_16;
			2'h2: div_mask = DIV_MASK_64;
			default: div_mask = DIV_MASK_512;
		endcase
	end
	assign pin_rise = shift_clock_pin_in && !pin_prev_reg;
	assign pin_fall = !shift_clock_pin_in && pin_prev_reg;
	assign src_tick = ext_clk ? pin_rise : (presc_reg & div_mask) == div_mask;
	assign brg_tick = src_tick && brg_cnt_reg == RESET_8;

	// free prescaler; the reload counter gives one tick per n+1 source ticks
	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			presc_reg <= '0;
			brg_cnt_reg <= RESET_8;
			pin_prev_reg <= 1'b1;
		end else begin
			presc_reg <= presc_reg + 9'h001;
			pin_prev_reg <= shift_clock_pin_in;
			if (src_tick)
				brg_cnt_reg <= brg_tick ? baud_reg : brg_cnt_reg - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// transmitter, also the source of synchronous shift clocks
	// ----------------------------------------------------------------
	tx_state_e tx_state;
	logic [8:0] tx_shift_reg;
	logic [3:0] tx_cnt_reg, tx_os_reg, len;
	logic tx_out_reg, clk_out_reg, tx_par_reg, tx_load, sync_active, bit_end;
	logic sclk_fall, sclk_rise;

	assign len = char_len(mode_reg[2:0]);
	// a handshake input only gates the start when that function is chosen
	assign tx_load = tx_state == TX_IDLE && tx_en_reg && !tx_empty_reg
		&& (is_sync || is_uart) && (rts_fn || !permit_to_send_in);
	assign sync_active = is_sync && tx_state == TX_DATA;
	assign sclk_fall = sync_active && (ext_clk ? pin_fall : brg_tick && clk_out_reg);
	assign sclk_rise = sync_active && (ext_clk ? pin_rise : brg_tick && !clk_out_reg);
	assign bit_end = brg_tick && tx_os_reg == OS_LAST;

	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			tx_state <= TX_IDLE;
			tx_shift_reg <= '0;
			tx_cnt_reg <= '0;
			tx_os_reg <= '0;
			tx_out_reg <= 1'b1;
			clk_out_reg <= 1'b1;
			tx_par_reg <= 1'b0;
		end else begin
			if (brg_tick)
				tx_os_reg <= tx_os_reg + 4'h1;
			unique case (tx_state)
				TX_IDLE: begin
					tx_out_reg <= 1'b1;
					clk_out_reg <= 1'b1;
					if (tx_load) begin
						tx_shift_reg <= txbuf_reg;
						tx_par_reg <= (^(txbuf_reg & ~(9'h1ff << len))) ^ !mode_reg[MODE_EVEN_BIT];
						tx_cnt_reg <= '0;
						tx_os_reg <= '0;
						if (is_sync) begin
							tx_state <= TX_DATA;
						end else begin
							tx_state <= TX_START;
							tx_out_reg <= 1'b0;
						end
					end
				end
				TX_START: if (bit_end) begin
					tx_state <= TX_DATA;
					tx_out_reg <= tx_shift_reg[0];
					tx_shift_reg <= tx_shift_reg >> 1;
					tx_cnt_reg <= 4'h1;
				end
				TX_DATA: begin
					if (is_sync) begin
						if (!ext_clk && brg_tick)
							clk_out_reg <= !clk_out_reg;
						if (sclk_fall) begin
							tx_out_reg <= tx_shift_reg[0];
							tx_shift_reg <= tx_shift_reg >> 1;
						end
						if (sclk_rise) begin
							tx_cnt_reg <= tx_cnt_reg + 4'h1;
							if (tx_cnt_reg == SYNC_LAST)
								tx_state <= TX_IDLE;
						end
					end else if (bit_end) begin
						if (tx_cnt_reg == len) begin
							tx_cnt_reg <= '0;
							if (mode_reg[MODE_PAR_BIT]) begin
								tx_state <= TX_PARITY;
								tx_out_reg <= tx_par_reg;
							end else begin
								tx_state <= TX_STOP;
								tx_out_reg <= 1'b1;
							end
						end else begin
							tx_out_reg <= tx_shift_reg[0];
							tx_shift_reg <= tx_shift_reg >> 1;
							tx_cnt_reg <= tx_cnt_reg + 4'h1;
						end
					end
				end
				TX_PARITY: if (bit_end) begin
					tx_state <= TX_STOP;
					tx_out_reg <= 1'b1;
				end
				TX_STOP: if (bit_end) begin
					if (mode_reg[MODE_STOP2_BIT] && tx_cnt_reg == '0)
						tx_cnt_reg <= 4'h1;
					else
						tx_state <= TX_IDLE;
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// transmit buffer; a write landing with a load keeps the new data pending
	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			txbuf_reg <= '0;
			tx_empty_reg <= 1'b1;
			tx_reg_empty_reg <= 1'b1;
			tx_req_reg <= 1'b0;
		end else begin
			if (tx_load)
				tx_empty_reg <= 1'b1;
			if (wr_done && paddr == ADDR_TXBUF) begin
				txbuf_reg <= pwdata[8:0];
				tx_empty_reg <= 1'b0;
			end
			if (tx_load)
				tx_reg_empty_reg <= 1'b0;
			else if (tx_state != TX_IDLE && tx_state_next_idle())
				tx_reg_empty_reg <= 1'b1;
			if (wr_done && paddr == ADDR_REQ && pwdata[REQ_TX])
				tx_req_reg <= 1'b0;
			if (tx_load)
				tx_req_reg <= 1'b1;
		end
	end

	// true in the cycle that the transmitter finishes its last bit
	function automatic logic tx_state_next_idle();
		tx_state_next_idle = (tx_state == TX_DATA && sclk_rise && tx_cnt_reg == SYNC_LAST)
			|| (tx_state == TX_STOP && bit_end
			&& !(mode_reg[MODE_STOP2_BIT] && tx_cnt_reg == '0));
	endfunction : tx_state_next_idle

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	rx_state_e rx_state;
	logic [8:0] rx_shift_reg, rx_shift_next, rx_char_reg;
	logic [3:0] rx_cnt_reg, rx_os_reg;
	logic rx_par_reg, rx_done_reg, rx_perr_reg, rx_ferr_reg, rx_busy, rx_sample;

	assign rx_busy = rx_state != RX_IDLE;
	assign rx_shift_next = {serial_in_pin, rx_shift_reg[8:1]};
	assign rx_sample = brg_tick && rx_os_reg == OS_LAST;

	// right-align the character held at the top of the shift register
	function automatic logic [8:0] align_char(input logic [8:0] s, input logic [3:0] n);
		align_char = s >> (4'h9 - n);
	endfunction : align_char

	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			rx_state <= RX_IDLE;
			rx_shift_reg <= '0;
			rx_cnt_reg <= '0;
			rx_os_reg <= '0;
			rx_par_reg <= 1'b0;
			rx_done_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
			rx_ferr_reg <= 1'b0;
			rx_char_reg <= '0;
		end else begin
			rx_done_reg <= 1'b0;
			if (brg_tick)
				rx_os_reg <= rx_os_reg + 4'h1;
			if (!rx_en_reg) begin
				rx_state <= RX_IDLE;
			end else begin
				unique case (rx_state)
					RX_IDLE: begin
						rx_cnt_reg <= '0;
						rx_par_reg <= 1'b0;
						// synchronous reception rides on a transmitter start
						if (is_sync && tx_load)
							rx_state <= RX_DATA;
						else if (is_uart && !serial_in_pin) begin
							rx_state <= RX_START;
							rx_os_reg <= '0;
						end
					end
					RX_START: if (brg_tick && rx_os_reg == OS_MID) begin
						// a glitch shorter than half a bit is not a start bit
						rx_state <= serial_in_pin ? RX_IDLE : RX_DATA;
						rx_os_reg <= '0;
					end
					RX_DATA: if (is_sync ? sclk_rise : rx_sample) begin
						rx_shift_reg <= rx_shift_next;
						rx_par_reg <= rx_par_reg ^ serial_in_pin;
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
						if (is_sync && rx_cnt_reg == SYNC_LAST) begin
							rx_state <= RX_IDLE;
							rx_char_reg <= align_char(rx_shift_next, LEN_8);
							rx_perr_reg <= 1'b0;
							rx_ferr_reg <= 1'b0;
							rx_done_reg <= 1'b1;
						end else if (!is_sync && rx_cnt_reg == len - 4'h1)
							rx_state <= mode_reg[MODE_PAR_BIT] ? RX_PARITY : RX_STOP;
					end
					RX_PARITY: if (rx_sample) begin
						rx_state <= RX_STOP;
						rx_perr_reg <= (rx_par_reg ^ serial_in_pin) == mode_reg[MODE_EVEN_BIT];
					end
					RX_STOP: if (rx_sample) begin
						rx_state <= RX_IDLE;
						rx_char_reg <= align_char(rx_shift_reg, len);
						rx_ferr_reg <= !serial_in_pin;
						if (!mode_reg[MODE_PAR_BIT])
							rx_perr_reg <= 1'b0;
						rx_done_reg <= 1'b1;
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// receive buffer and status flags
	// ----------------------------------------------------------------
	logic keep_char, overrun_evt;
	// sleep drops characters whose top data bit is clear
	assign keep_char = !(is_uart && mode_reg[MODE_SLEEP_BIT] && !rx_char_reg[len - 4'h1]);
	// a read in the same cycle has emptied the buffer, so no overrun then
	assign overrun_evt = rx_done_reg && keep_char && rx_complete_reg && !rd_rxbuf;

	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			rx_buf_reg <= '0;
			rx_complete_reg <= 1'b0;
			overrun_reg <= 1'b0;
			perr_reg <= 1'b0;
			ferr_reg <= 1'b0;
			rx_req_reg <= 1'b0;
		end else begin
			if (rd_rxbuf)
				rx_complete_reg <= 1'b0;
			if (!rx_en_reg) begin
				overrun_reg <= 1'b0;
				perr_reg <= 1'b0;
				ferr_reg <= 1'b0;
			end
			if (wr_done && paddr == ADDR_REQ && pwdata[REQ_RX])
				rx_req_reg <= 1'b0;
			// new data wins over any clear in the same cycle
			if (rx_done_reg && keep_char) begin
				rx_buf_reg <= rx_char_reg;
				rx_complete_reg <= 1'b1;
				perr_reg <= perr_reg | rx_perr_reg;
				ferr_reg <= ferr_reg | rx_ferr_reg;
				if (overrun_evt)
					overrun_reg <= 1'b1;
				else
					rx_req_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin outputs
	// ----------------------------------------------------------------
	logic rts_reg, clk_oe_reg;
	// ready output: with the handshake function chosen, low while waiting, high during a reception; otherwise always high
	always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
		if (!rst_n_sync_reg) begin
			rts_reg <= 1'b1;
			clk_oe_reg <= 1'b0;
		end else begin
			rts_reg <= !(rts_fn && rx_en_reg && !rx_busy);
			clk_oe_reg <= is_sync && !ext_clk;
		end
	end
	assign ready_to_accept_out = rts_reg;
	assign serial_out_pin = tx_out_reg;
	assign shift_clock_pin_out = clk_out_reg;
	assign shift_clock_pin_oe = clk_oe_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n_sync_reg);

	property p_sync_rx_needs_tx;
		(rx_state == RX_IDLE && is_sync) ##1 rx_state == RX_DATA |-> $past(tx_en_reg);
	endproperty
	a_sync_rx_needs_tx: assert property (p_sync_rx_needs_tx) else $error("sync rx without tx");
	property p_rts_high_on_start;
		rts_fn && rx_en_reg && !rx_busy ##1 rx_busy && rts_fn |=> ready_to_accept_out;
	endproperty
	a_rts_high_on_start: assert property (p_rts_high_on_start) else $error("ready not high");
	property p_shift_top_bit;
		rx_state == RX_DATA && is_sync && sclk_rise && rx_en_reg
			|=> rx_shift_reg[8] == $past(serial_in_pin);
	endproperty
	a_shift_top_bit: assert property (p_shift_top_bit) else $error("top bit not loaded");
	property p_done_sets_flag;
		rx_done_reg && keep_char |=> rx_complete_reg && rx_buf_reg == $past(rx_char_reg);
	endproperty
	a_done_sets_flag: assert property (p_done_sets_flag) else $error("buffer not loaded");
	property p_request_on_done;
		rx_done_reg && keep_char && !rx_complete_reg |=> rx_req_reg;
	endproperty
	a_request_on_done: assert property (p_request_on_done) else $error("no rx request");
	property p_read_clears;
		rd_rxbuf && !rx_done_reg |=> !rx_complete_reg;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear");
	property p_overrun_no_req;
		overrun_evt && !rx_req_reg |=> overrun_reg && !rx_req_reg;
	endproperty
	a_overrun_no_req: assert property (p_overrun_no_req) else $error("overrun raised req");
	property p_start_low;
		tx_state == TX_START |-> !serial_out_pin;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");
	property p_stop_high;
		tx_state == TX_STOP |-> serial_out_pin;
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
	property p_sync_lsb_first;
		sclk_fall |=> serial_out_pin == $past(tx_shift_reg[0]);
	endproperty
	a_sync_lsb_first: assert property (p_sync_lsb_first) else $error("wrong sync bit");
	c_sync_byte: cover property (rx_done_reg && is_sync);
	c_uart_frame: cover property (rx_done_reg && is_uart && mode_reg[MODE_PAR_BIT]);
	c_overrun: cover property (overrun_evt);
endmodule : serial_io_uart
`default_nettype wire

/* bench/serial_peer.sv */
// peer model: external synchronous serial device on the far side of the channel
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	input wire logic sck,
	input wire logic sout,
	input wire logic [7:0] send_byte,
	output logic sin,
	output logic [7:0] got_byte,
	output int frames
);
	int idx = 0;
	logic armed = 1'b0;
	initial begin
		sin = 1'b1;
		got_byte = 8'h00;
		frames = 0;
	end
	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	// next bit goes out on the fall so it is settled before the rise samples it
	always @(negedge sck) begin
		armed <= 1'b1;
		sin <= send_byte[idx];
	end
	// collect transmit data; after the last bit the line stops holding its value
	always @(posedge sck) begin
		if (armed) begin
			got_byte <= {sout, got_byte[7:1]};
			idx <= (idx == 7) ? 0 : idx + 1;
			if (idx == 7) begin
				frames <= frames + 1;
				sin <= ~sin;
			end
		end
	end
endmodule : serial_peer
`default_nettype wire

/* bench/tb_top.sv */
// testbench: apb master, synchronous receive rows, overrun, receiver off, uart loopback, bus error
`timescale 1ns/1ps
`default_nettype none
module tb_top import serial_io_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, permit_to_send_in = 1'b0, err;
	logic [7:0] paddr = 8'h00, send_byte = 8'h00, got_byte;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, peer_sin, serial_out_pin, shift_clock_pin_out, loop = 1'b0;
	logic shift_clock_pin_oe, ready_to_accept_out;
	int frames, num_errors = 0, checked = 0;
	logic [15:0] rows [3] = '{16'h00ff, 16'ha55a, 16'h0180}; // {dummy, received}
	// clock pin: the channel drives it when enabled, otherwise a pull-up holds it high
	wire logic sck = shift_clock_pin_oe ? shift_clock_pin_out : 1'b1;
	// loopback lets the channel hear its own asynchronous frames
	wire logic serial_in_pin = loop ? serial_out_pin : peer_sin;
	serial_io_uart u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .serial_in_pin, .serial_out_pin, .shift_clock_pin_in(sck),
		.shift_clock_pin_out, .shift_clock_pin_oe, .permit_to_send_in, .ready_to_accept_out);
	serial_peer u_peer (.sck, .sout(serial_out_pin), .send_byte, .sin(peer_sin), .got_byte,
		.frames);
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic give_up(input string m);
		num_errors++;
		$display("unexpected at %0t: timeout %s", $time, m);
		complete_run();
	endtask : give_up
	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) give_up("bus");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// bounded wait for one byte on the link, handshake output checked around it
	task automatic wait_byte(input logic rx_on);
		int n;
		int f;
		f = frames;
		n = 0;
		while (sck !== 1'b0 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		chk(ready_to_accept_out, 32'h1, "ready high in byte");
		while (frames == f && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 300) give_up("link");
		repeat (4) @(posedge sys_clk);
		chk(ready_to_accept_out, {31'h0, !rx_on}, "ready after byte");
	endtask : wait_byte
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		repeat (3) @(posedge sys_clk);
		chk({shift_clock_pin_out, serial_out_pin, ready_to_accept_out}, 32'h7, "reset pins");
		$display("reset test done");
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		apb(1'b1, ADDR_MODE, {29'h0, MODE_SYNC});
		apb(1'b1, ADDR_CTRL0, 32'h4);
		apb(1'b1, ADDR_BAUD, 32'h0);
		apb(1'b1, ADDR_CTRL1, 32'h5);
		repeat (2) @(posedge sys_clk);
		chk(ready_to_accept_out, 32'h0, "ready low on enable");
		chk(shift_clock_pin_oe, 32'h1, "clock pin driven");
		foreach (rows[i]) begin
			send_byte <= rows[i][7:0];
			apb(1'b1, ADDR_TXBUF, {24'h0, rows[i][15:8]});
			wait_byte(1'b1);
			chk(got_byte, rows[i][15:8], "dummy on tx");
			apb(1'b0, ADDR_CTRL1, 32'h0);
			chk(rd[C1_RX_DONE], 32'h1, "flag set");
			apb(1'b0, ADDR_REQ, 32'h0);
			chk(rd[REQ_RX], 32'h1, "rx request");
			apb(1'b0, ADDR_RXBUF, 32'h0);
			chk(rd, {24'h0, rows[i][7:0]}, "rx byte");
			apb(1'b0, ADDR_CTRL1, 32'h0);
			chk(rd[C1_RX_DONE], 32'h0, "flag cleared");
			apb(1'b1, ADDR_REQ, 32'h1);
			$display("row %0d done", i);
		end
		// second byte lands before the first is read
		send_byte <= 8'h3c;
		apb(1'b1, ADDR_TXBUF, 32'h11);
		wait_byte(1'b1);
		apb(1'b1, ADDR_REQ, 32'h1);
		send_byte <= 8'hc3;
		apb(1'b1, ADDR_TXBUF, 32'h22);
		wait_byte(1'b1);
		apb(1'b0, ADDR_CTRL1, 32'h0);
		chk({rd[C1_ERR_SUM], rd[C1_OVERRUN]}, 32'h3, "overrun flag");
		apb(1'b0, ADDR_REQ, 32'h0);
		chk(rd[REQ_RX], 32'h0, "no request on overrun");
		apb(1'b0, ADDR_RXBUF, 32'h0);
		chk(rd, 32'hc3, "overwritten byte");
		$display("overrun test done");
		// transmitter alone must not receive
		apb(1'b1, ADDR_CTRL1, 32'h1);
		send_byte <= 8'h77;
		apb(1'b1, ADDR_TXBUF, 32'h33);
		wait_byte(1'b0);
		apb(1'b0, ADDR_CTRL1, 32'h0);
		chk(rd[C1_RX_DONE], 32'h0, "no rx without enable");
		$display("receiver off test done");
		// 8-bit asynchronous frame, even parity, looped back into the receiver
		loop <= 1'b1;
		apb(1'b1, ADDR_MODE, 32'h65);
		apb(1'b1, ADDR_CTRL1, 32'h5);
		apb(1'b1, ADDR_TXBUF, 32'h96);
		n = 0;
		do begin
			apb(1'b0, ADDR_CTRL1, 32'h0);
			n++;
		end while (rd[C1_RX_DONE] !== 1'b1 && n < 200);
		if (n >= 200) give_up("uart");
		chk(rd[C1_PARITY:C1_FRAMING], 32'h0, "uart errors");
		apb(1'b0, ADDR_RXBUF, 32'h0);
		chk(rd, 32'h96, "uart byte");
		$display("uart test done");
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped read");
		$display("bus error test done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
